/* File: hw/power_mode_reset_sequencer.sv */
// power-on reset timing, idle and power-down sequencing, wake and pll lock
// assumes supply detector levels and interrupt levels come from other domains
// Function
// - hold chip reset while the supply-low indication is active.
// - after supply recovers, wait 128 ms before releasing reset.
// - keep reset on a falling supply until below 1 V.
// - control bit 0 enters idle, bit 1 enters power-down.
// - idle keeps oscillator, stops core clock, peripherals keep clocking.
// - idle keeps core state and ports; address latch and store enable high.
// - idle ends on any enabled interrupt or hardware reset.
// - power-down stops pll and core clock.
// - power-down stops oscillator only when oscillator power-down bit set.
// - power-down stops all peripherals; the interval wake counter keeps running only while the oscillator does.
// - power-down keeps ports, tri-states converter, latch and store enable low.
// - external reset pin ends power-down; execution restarts after release.
// - interval counter interrupt wakes power-down when oscillator stays on.
// - enabled spi interrupt wakes power-down when spi wake enable set.
// - enabled external interrupt 0 wakes when its wake enable set.
// - after wake, return from interrupt resumes after the power-down entry.
// - after wake, code runs while the pll relocks for about 1 ms.
// - add 150 ms oscillator start-up when oscillator was stopped.
`include "pwr_seq_regs.svh"

module power_mode_reset_sequencer #(
  parameter pwr_seq_pkg::count_t PorCycles  = `POR_CYCLES,
  parameter pwr_seq_pkg::count_t LockCycles = `PLL_LOCK_CYCLES,
  parameter pwr_seq_pkg::count_t OscCycles  = `OSC_START_CYCLES
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic supplyLow,
  input  wire logic supplyAboveOneVolt,
  input  wire logic resetPin,
  input  wire logic idleReq,
  input  wire logic powerDownReq,
  input  wire logic oscPowerdownBit,
  input  wire logic spiWakeEnable,
  input  wire logic extInt0WakeEnable,
  input  wire logic anyIntPending,
  input  wire logic intervalWakeIrq,
  input  wire logic spiIrq,
  input  wire logic extInterruptZeroIrq,
  output logic      chipReset,
  output logic      coreClkEn,
  output logic      pllEn,
  output logic      oscEn,
  output logic      periphClkEn,
  output logic      intervalCounterClkEn,
  output logic      portHold,
  output logic      dacOutEn,
  output logic      addrLatchOut,
  output logic      programStoreEnableOut,
  output logic      pllLocked,
  output logic      wakeServiceReq
);
  import pwr_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for all foreign levels
  localparam int NS = 10;
  logic [NS-1:0] syncA_q, syncB_q;
  logic [NS-1:0] rawIn;
  assign rawIn = {supplyLow, supplyAboveOneVolt, resetPin, idleReq, powerDownReq,
                  anyIntPending, intervalWakeIrq, spiIrq, extInterruptZeroIrq,
                  oscPowerdownBit};
  always_ff @(posedge clock) begin
    syncA_q <= rawIn;
    syncB_q <= syncA_q;
  end
  logic sLow, sAbove1, sRstPin, sIdle, sPdown, sAnyInt, sTic, sSpi, sInt0, sOscPd;
  assign {sLow, sAbove1, sRstPin, sIdle, sPdown, sAnyInt, sTic, sSpi, sInt0, sOscPd} =
         syncB_q;

  function automatic count_t satDec(input count_t c);
    satDec = (c == '0) ? '0 : c - 32'h00000001;
  endfunction : satDec

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  pwr_state_e state_q, state_d;
  count_t     cnt_q, cnt_d;
  count_t     lockCnt_q, lockCnt_d;
  logic       oscOff_q, oscOff_d;
  logic       wakeIrq;
  logic       wakeSrc;

  // tic wake only meaningful with oscillator alive
  assign wakeSrc = (sTic & ~oscOff_q)
                 | (sSpi & spiWakeEnable)
                 | (sInt0 & extInt0WakeEnable);
  assign wakeIrq = wakeSrc;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    lockCnt_d = satDec(lockCnt_q);
    oscOff_d  = oscOff_q;
    case (state_q)
      ST_POR: begin
        // supply low (or falling, until detector drops) restarts the timeout
        if (sLow) begin
          cnt_d = PorCycles;
        end else if (cnt_q == '0) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = satDec(cnt_q);
        end
      end
      ST_RUN: begin
        // power-down wins when both bits are written together
        if (sPdown) begin
          state_d  = ST_PDOWN;
          oscOff_d = sOscPd;
        end else if (sIdle) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (sAnyInt) begin
          state_d = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (wakeIrq) begin
          state_d = ST_WAKE;
          // stopped oscillator must start before the pll can lock
          cnt_d     = oscOff_q ? OscCycles : '0;
          lockCnt_d = LockCycles;
          oscOff_d  = 1'b0;
        end
      end
      ST_WAKE: begin
        // core resumes at once; lock counter is held at LockCycles until RUN
        if (cnt_q == '0) begin
          state_d   = ST_RUN;
          lockCnt_d = LockCycles;
        end else begin
          cnt_d     = satDec(cnt_q);
          lockCnt_d = LockCycles;
        end
      end
      default: begin
        state_d = ST_POR;
        cnt_d   = PorCycles;
      end
    endcase
    // supply loss or reset pin overrides any mode
    if (sLow || sRstPin) begin
      state_d   = ST_POR;
      cnt_d     = sLow ? PorCycles : '0;
      lockCnt_d = '0;
      oscOff_d  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q   <= ST_POR;
      cnt_q     <= PorCycles;
      lockCnt_q <= '0;
      oscOff_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      lockCnt_q <= lockCnt_d;
      oscOff_q  <= oscOff_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic rst_d, core_d, pll_d, osc_d, per_d, tic_d, hold_d, dac_d, ale_d, pse_d;
  logic lock_d, wsr_d;
  always_comb begin
    rst_d  = (state_d == ST_POR);
    core_d = (state_d == ST_RUN) || (state_d == ST_WAKE);
    pll_d  = (state_d != ST_PDOWN) && (state_d != ST_WAKE || cnt_d == '0);
    osc_d  = !((state_d == ST_PDOWN) && oscOff_d)
             && !((state_d == ST_WAKE) && cnt_d != '0);
    per_d  = (state_d != ST_PDOWN);
    tic_d  = osc_d;
    hold_d = (state_d == ST_IDLE) || (state_d == ST_PDOWN);
    dac_d  = (state_d != ST_PDOWN) && (state_d != ST_POR);
    ale_d  = (state_d != ST_PDOWN);
    pse_d  = (state_d != ST_PDOWN);
    lock_d = pll_d && (lockCnt_d == '0) && (state_d != ST_WAKE);
    wsr_d  = (state_q == ST_PDOWN) && (state_d == ST_WAKE);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chipReset             <= 1'b1;
      coreClkEn             <= 1'b0;
      pllEn                 <= 1'b1;
      oscEn                 <= 1'b1;
      periphClkEn           <= 1'b1;
      intervalCounterClkEn  <= 1'b1;
      portHold              <= 1'b0;
      dacOutEn              <= 1'b0;
      addrLatchOut          <= 1'b1;
      programStoreEnableOut <= 1'b1;
      pllLocked             <= 1'b0;
      wakeServiceReq        <= 1'b0;
    end else begin
      chipReset             <= rst_d;
      coreClkEn             <= core_d;
      pllEn                 <= pll_d;
      oscEn                 <= osc_d;
      periphClkEn           <= per_d;
      intervalCounterClkEn  <= tic_d;
      portHold              <= hold_d;
      dacOutEn              <= dac_d;
      addrLatchOut          <= ale_d;
      programStoreEnableOut <= pse_d;
      pllLocked             <= lock_d;
      wakeServiceReq        <= wsr_d;
    end
  end
endmodule : power_mode_reset_sequencer

/* File: pkg/pwr_seq_pkg.sv */
// types for the power mode sequencer
// assumes pwr_seq_regs.svh supplies the numeric constants
package pwr_seq_pkg;
  typedef enum logic [4:0] {
    ST_POR   = 5'b00001,
    ST_RUN   = 5'b00010,
    ST_IDLE  = 5'b00100,
    ST_PDOWN = 5'b01000,
    ST_WAKE  = 5'b10000
  } pwr_state_e;
  typedef logic [31:0] count_t;
endpackage : pwr_seq_pkg

/* File: pkg/pwr_seq_regs.svh */
// timing counts and control bit positions for the power mode sequencer
// assumes a 200 MHz system clock; long counts are overridable parameters
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CLK_MHZ            200
`define POR_TIMEOUT_MS     128
`define PLL_LOCK_MS        1
`define OSC_START_MS       150
`define POR_CYCLES         (`POR_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define PLL_LOCK_CYCLES    (`PLL_LOCK_MS * 1000 * `CLK_MHZ)
`define OSC_START_CYCLES   (`OSC_START_MS * 1000 * `CLK_MHZ)
`define PCTL_IDLE_BIT      0
`define PCTL_PDOWN_BIT     1
`define PLLCTL_LOCK_BIT    6
`endif

/* File: tb/pwr_seq_assertions.sv */
// port checks for the power mode sequencer
// assumes binding into every sequencer instance
module pwr_seq_assertions (
  input logic clock, sys_rst, supplyLow, oscPowerdownBit,
  input logic spiIrq, spiWakeEnable, extInterruptZeroIrq, extInt0WakeEnable,
  input logic chipReset, coreClkEn, pllEn, oscEn, periphClkEn, intervalCounterClkEn,
  input logic portHold, dacOutEn, addrLatchOut, programStoreEnableOut, wakeServiceReq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic pdown;
  assign pdown = portHold && !addrLatchOut;
  supply_hold_a: assert property ($rose(supplyLow) |-> ##[1:4] chipReset)
    else $error("reset missed a low supply");
  por_delay_a: assert property ($fell(chipReset) |-> !$past(supplyLow, 8))
    else $error("reset released too early");
  idle_pins_a: assert property (portHold && addrLatchOut |-> oscEn && periphClkEn
    && !coreClkEn && programStoreEnableOut) else $error("idle outputs wrong");
  pdown_pins_a: assert property (pdown |-> !(pllEn || coreClkEn || periphClkEn
    || dacOutEn || programStoreEnableOut) && intervalCounterClkEn == oscEn)
    else $error("power-down outputs wrong");
  osc_bit_a: assert property (pdown |-> oscEn != oscPowerdownBit)
    else $error("oscillator state wrong");
  pulse_once_a: assert property (wakeServiceReq |=> !wakeServiceReq && !portHold)
    else $error("wake pulse wrong");
  spi_wake_a: assert property (pdown && spiIrq && spiWakeEnable |-> ##[1:5] wakeServiceReq)
    else $error("spi wake missed");
  ext_wake_a: assert property (pdown && extInterruptZeroIrq && extInt0WakeEnable
    |-> ##[1:5] wakeServiceReq) else $error("ext wake missed");
endmodule : pwr_seq_assertions
////////////////////////////////////////////////////////////////////////
bind power_mode_reset_sequencer pwr_seq_assertions i_pwr_seq_assertions (.*);

/* File: tb/supply_detector.sv */
// supply-level detector model
// assumes the bench sets the supply in millivolts
module supply_detector (
  input  int   mv,
  output logic supplyLow,
  output logic supplyAboveOneVolt
);
  timeunit 1ns;
  timeprecision 1ps;
  assign supplyLow = mv < 2450;
  assign supplyAboveOneVolt = mv > 1000;
endmodule : supply_detector

/* File: tb/testbench.sv */
// self-checking bench for the power mode sequencer
// assumes design, checker and detector compile first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, sys_rst = 1, resetPin = 0, idleReq = 0, powerDownReq = 0, hit;
  logic oscPowerdownBit = 0, spiWakeEnable = 0, extInt0WakeEnable = 0, anyIntPending = 0;
  logic intervalWakeIrq = 0, spiIrq = 0, extInterruptZeroIrq = 0, supplyLow, supplyAboveOneVolt;
  logic chipReset, coreClkEn, pllEn, oscEn, periphClkEn, intervalCounterClkEn, portHold;
  logic dacOutEn, addrLatchOut, programStoreEnableOut, pllLocked, wakeServiceReq;
  int mv = 3300, fails = 0, checked = 0, cyc = 0, n;
  logic [31:0] rng = 32'h0000f74b;
  always #2.5 clock = ~clock;
  power_mode_reset_sequencer #(.PorCycles(20), .LockCycles(10), .OscCycles(30))
    i_power_mode_reset_sequencer (.*);
  supply_detector i_supply_detector (.*);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // interval wake only works with a live oscillator
  function automatic logic exp_wake(input int src);
    return src == 0 ? !oscPowerdownBit : (src == 1 ? spiWakeEnable : extInt0WakeEnable);
  endfunction : exp_wake
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic cmp(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    tick(2);
    sys_rst <= 0;
    mv <= 1800;
    tick(10);
    cmp(chipReset, 1);
    mv <= 600;
    tick(10);
    cmp(chipReset, 1);
    mv <= 3300;
    for (n = 0; n < 60 && chipReset !== 0; n++) tick();
    cmp(n >= 20 && n < 30, 1);
    $display("power-on test done");
    idleReq <= 1;
    spiIrq <= 1;
    spiWakeEnable <= 1;
    tick();
    idleReq <= 0;
    tick(6);
    cmp(portHold, 1);
    cmp(coreClkEn, 0);
    cmp(addrLatchOut, 1);
    cmp(programStoreEnableOut, 1);
    cmp(oscEn, 1);
    cmp(periphClkEn, 1);
    anyIntPending <= 1;
    spiIrq <= 0;
    tick(6);
    cmp(portHold, 0);
    anyIntPending <= 0;
    $display("idle test done");
    for (int i = 0; i < 9; i++) begin
      rng = xs(rng);
      oscPowerdownBit <= i > 2 && rng[0];
      spiWakeEnable <= i < 3 || rng[3];
      extInt0WakeEnable <= i < 3 || rng[4];
      powerDownReq <= 1;
      tick();
      powerDownReq <= 0;
      tick(5);
      cmp(addrLatchOut, 0);
      cmp(pllEn, 0);
      cmp(oscEn, !oscPowerdownBit);
      cmp(periphClkEn, 0);
      cmp(intervalCounterClkEn, !oscPowerdownBit);
      cmp(dacOutEn, 0);
      cmp(programStoreEnableOut, 0);
      cmp(coreClkEn, 0);
      {extInterruptZeroIrq, spiIrq, intervalWakeIrq} <= 3'h1 << (i % 3);
      for (n = 0; n < 8 && wakeServiceReq !== 1; n++) tick();
      hit = n < 8;
      cmp(hit, exp_wake(i % 3));
      {extInterruptZeroIrq, spiIrq, intervalWakeIrq} <= 3'h0;
      if (hit) begin
        for (n = 0; n < 80 && pllLocked !== 1; n++) tick();
        cmp(n >= (oscPowerdownBit ? 40 : 10) && n <= (oscPowerdownBit ? 55 : 25), 1);
      end else begin
        resetPin <= 1;
        tick(4);
        cmp(chipReset, 1);
        resetPin <= 0;
        for (n = 0; n < 8 && chipReset !== 0; n++) tick();
        cmp(n < 8, 1);
      end
      tick(2);
      $display("power-down test %0d done", i);
    end
    close_out();
  end
endmodule : testbench
